// ---- core/aats_edge_sync.sv ----
`timescale 1ns/100ps
// two-flop synchroniser followed by a rising-edge detector, per lane
module aats_edge_sync #(
    parameter int W = 18
) (
    input  wire logic         CORE_CLK,
    input  wire logic         RST_N,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_reg, meta_next;
    logic [W-1:0] sync_reg, sync_next;
    logic [W-1:0] last_reg, last_next;
    logic [W-1:0] rise_reg, rise_next;

    // meta feeds only the second stage; edge taken on synced copy
    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
        last_next = sync_reg;
        rise_next = sync_reg & ~last_reg;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
            rise_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
            rise_reg <= rise_next;
        end
    end

    assign rise = rise_reg;
endmodule

// ---- core/aats_pkg.sv ----
package aats_pkg;

    // trigger selector codes
    localparam logic [4:0] SEL_OFF       = 5'h00;
    localparam logic [4:0] SEL_PIN       = 5'h01;
    localparam logic [4:0] SEL_TMR_ZERO  = 5'h02;
    localparam logic [4:0] SEL_TMR_ONE   = 5'h03;
    localparam logic [4:0] SEL_TMR_TWO   = 5'h04;
    localparam logic [4:0] SEL_CCP_FIRST = 5'h05;
    localparam logic [4:0] SEL_CMP_ONE   = 5'h0C;
    localparam logic [4:0] SEL_CMP_TWO   = 5'h0D;
    localparam logic [4:0] SEL_PIN_CHG   = 5'h0E;
    localparam logic [4:0] SEL_CELL_ONE  = 5'h0F;
    localparam logic [4:0] SEL_LAST      = 5'h12;

    localparam int SEL_W      = 5;
    localparam int RES_W      = 10;   // 1024 steps
    localparam int SYNC_W     = 18;   // one lane per defined source code 0x01..0x12

    // conversion timing: clock period in ps, conversion time in ns, count in core clock cycles
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int CONV_TIME_NS     = 2000;
    localparam int CONV_CYCLES      = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // hardware trigger sources, one bit each
    typedef struct packed {
        logic       logic_cell_four;
        logic       logic_cell_three;
        logic       logic_cell_two;
        logic       logic_cell_one;
        logic       pin_change_flag;
        logic       comparator_two_output;
        logic       comparator_one_output;
        logic       numeric_oscillator_one;
        logic       pulse_width_six;
        logic       pulse_width_five;
        logic       pulse_width_four;
        logic       pulse_width_three;
        logic       capture_compare_two;
        logic       capture_compare_one;
        logic       timer_two_match;
        logic       timer_one_overflow;
        logic       timer_zero_overflow;
        logic       trigger_pin_router;
    } aats_src_t;

    // software write strobe into the control bits
    typedef struct packed {
        logic       wr;
        logic       converter_on;
        logic       conversion_go_bit;
    } aats_ctl_t;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_FINISH} aats_state_t;

endpackage

// ---- core/aats_sequencer.sv ----
`timescale 1ns/100ps
// Operation
// - rising edge of the chosen source sets the go bit without software
// - codes 05-0B pick capture, pulse and oscillator; 0F-12 pick logic cells
// - code 00 disables hardware triggering completely
// - code 01 takes the routed trigger pin
// - codes 02 and 03 take timer zero and timer one overflow
// - code 04 takes the timer two postscaled period match
// - codes 0C and 0D take comparator one and two outputs
// - code 0E takes the pin change flag
// - hardware trigger has no effect during sleep
// - hold capacitor is never discharged at end of conversion
// - result has 1024 steps, ten bits wide
// - on completion clear go bit, set done flag, update result
// - go cannot be set by the same write that turns converter on
module aats_sequencer
    import aats_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    input  wire logic                     CORE_CLK,
    input  wire logic                     RST_N,
    input  wire aats_pkg::aats_ctl_t      CTL,
    input  wire logic [aats_pkg::SEL_W-1:0] TRIGGER_SOURCE_SELECT,
    input  wire aats_pkg::aats_src_t      SRC,
    input  wire logic                     SLEEP,
    input  wire logic                     DONE_FLAG_CLR,
    input  wire logic [aats_pkg::RES_W-1:0] SAMPLE_IN,
    output logic                          CONVERTER_ON,
    output logic                          CONVERSION_GO_BIT,
    output logic                          CONVERSION_DONE_FLAG,
    output logic [aats_pkg::RES_W-1:0]    RESULT,
    output logic                          HOLD_DISCHARGE
);
    import aats_pkg::*;

    localparam int NSRC = $bits(aats_src_t);
    localparam int CW   = $clog2(CONV_CYC + 1);

    logic [NSRC-1:0]  src_rise;
    logic             hw_edge;
    logic             start;
    aats_state_t      state_reg, state_next;
    logic [CW-1:0]    cnt_reg, cnt_next;
    logic             on_reg, on_next;
    logic             go_reg, go_next;
    logic             done_reg, done_next;
    logic [RES_W-1:0] res_reg, res_next;

    // map a selector code to a source lane; 0 and reserved give no lane
    function automatic logic pick(input logic [SEL_W-1:0] sel,
                                  input logic [NSRC-1:0] lanes);
        logic r;
        r = 1'b0;
        if (sel != SEL_OFF && sel <= SEL_LAST) begin
            r = lanes[5'(sel - SEL_PIN)];
        end
        return r;
    endfunction

    // every lane is synchronised so switching selector yields no false edge
    aats_edge_sync #(
        .W   (NSRC)
    ) u_sync (
        .CORE_CLK (CORE_CLK),
        .RST_N    (RST_N),
        .din      (SRC),
        .rise     (src_rise)
    );

    // lane order follows the code table: pin, timers, ccp, pwm, nco, cmp, ioc, clc
    assign hw_edge = pick(TRIGGER_SOURCE_SELECT, src_rise);

    // trigger suppressed in sleep and while converter is off
    assign start = ((hw_edge && !SLEEP) ||
                    (CTL.wr && CTL.conversion_go_bit && on_reg))
                   && on_reg && (state_reg == ST_IDLE);

    // conversion sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        on_next    = on_reg;
        go_next    = go_reg;
        done_next  = done_reg;
        res_next   = res_reg;
        if (CTL.wr) begin
            on_next = CTL.converter_on;
        end
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    go_next    = 1'b1;
                    cnt_next   = CW'(CONV_CYC);
                    state_next = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                // turning the converter off aborts without a result
                if (CTL.wr && !CTL.converter_on) begin
                    go_next    = 1'b0;
                    state_next = ST_IDLE;
                end else if (cnt_reg <= CW'(1)) begin
                    state_next = ST_FINISH;
                end else begin
                    cnt_next = cnt_reg - CW'(1);
                end
            end
            ST_FINISH: begin
                go_next    = 1'b0;
                res_next   = SAMPLE_IN;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // set wins over a clear in the same cycle
        if (DONE_FLAG_CLR) begin
            done_next = 1'b0;
        end
        if (state_reg == ST_FINISH) begin
            done_next = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            on_reg    <= 1'b0;
            go_reg    <= 1'b0;
            done_reg  <= 1'b0;
            res_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            on_reg    <= on_next;
            go_reg    <= go_next;
            done_reg  <= done_next;
            res_reg   <= res_next;
        end
    end

    assign CONVERTER_ON         = on_reg;
    assign CONVERSION_GO_BIT    = go_reg;
    assign CONVERSION_DONE_FLAG = done_reg;
    assign RESULT               = res_reg;
    assign HOLD_DISCHARGE       = 1'b0;   // charge kept between conversions
endmodule

// ---- tb/aats_sequencer_props.sv ----
`timescale 1ns/100ps
module aats_sequencer_props
    import aats_pkg::*;
(
    input wire logic                   CORE_CLK,
    input wire logic                   RST_N,
    input wire aats_pkg::aats_ctl_t    CTL,
    input wire logic [4:0]             TRIGGER_SOURCE_SELECT,
    input wire aats_pkg::aats_src_t    SRC,
    input wire logic                   SLEEP,
    input wire logic                   DONE_FLAG_CLR,
    input wire logic [9:0]             SAMPLE_IN,
    input wire logic                   CONVERTER_ON,
    input wire logic                   CONVERSION_GO_BIT,
    input wire logic                   CONVERSION_DONE_FLAG,
    input wire logic [9:0]             RESULT,
    input wire logic                   HOLD_DISCHARGE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // normal end: go drops while the converter stays on
    sequence conv_end;
        $fell(CONVERSION_GO_BIT) && CONVERTER_ON;
    endsequence
    // software start request seen while idle with the converter already on
    sequence sw_request;
        CTL.wr && CTL.conversion_go_bit && CTL.converter_on && CONVERTER_ON
            && !CONVERSION_GO_BIT;
    endsequence
    hold_kept_a: assert property (!HOLD_DISCHARGE)
        else $error("hold discharged");
    on_follows_a: assert property (CTL.wr |=> CONVERTER_ON == $past(CTL.converter_on))
        else $error("enable not taken");
    same_write_a: assert property (CTL.wr && CTL.conversion_go_bit && !CONVERTER_ON
        |=> !CONVERSION_GO_BIT) else $error("start with enable write");
    end_update_a: assert property (conv_end |-> CONVERSION_DONE_FLAG
        && RESULT == $past(SAMPLE_IN)) else $error("completion wrong");
    done_cause_a: assert property ($rose(CONVERSION_DONE_FLAG) |-> $fell(CONVERSION_GO_BIT))
        else $error("done without end");
    result_cause_a: assert property (!$stable(RESULT) |-> conv_end)
        else $error("result moved");
    done_clear_a: assert property (DONE_FLAG_CLR && !CONVERSION_GO_BIT
        |=> !CONVERSION_DONE_FLAG) else $error("done not cleared");
    hw_gate_a: assert property ($rose(CONVERSION_GO_BIT) && !$past(CTL.wr)
        |-> !$past(SLEEP) && $past(TRIGGER_SOURCE_SELECT) inside {[5'h01:5'h12]})
        else $error("hardware start gated wrongly");
    sw_start_a: assert property (sw_request |=> CONVERSION_GO_BIT)
        else $error("software start not taken");
    abort_stop_a: assert property (CTL.wr && !CTL.converter_on && CONVERSION_GO_BIT
        |=> !CONVERSION_GO_BIT) else $error("turn off did not stop");
endmodule

// ---- tb/aats_src_model.sv ----
`timescale 1ns/100ps
// trigger peripherals: lanes idle low, a request raises the chosen ones
module aats_src_model
    import aats_pkg::*;
(
    input  wire logic          CORE_CLK,
    output aats_pkg::aats_src_t src
);
    logic [17:0] lanes = 18'h00000;
    assign src = lanes;
    // three cycles high so the two-flop synchroniser cannot miss it
    task automatic fire(input logic [17:0] mask);
        @(posedge CORE_CLK) #1 lanes = mask;
        repeat (3) @(posedge CORE_CLK);
        #1 lanes = 18'h00000;
    endtask
endmodule

// ---- tb/test_adc_auto_trigger_sequencer.sv ----
`timescale 1ns/100ps
module test_adc_auto_trigger_sequencer;
    import aats_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, sleep = 1'b0, clr = 1'b0;
    aats_ctl_t  ctl = '0;
    logic [4:0] sel = 5'h00;
    logic [9:0] sample = 10'h000, result;
    aats_src_t  src;
    logic       on, go, done;
    int         err_total = 0;
    int         num_checks = 0;
    always #2 clk = ~clk;
    // short conversion keeps the run brief
    aats_sequencer #(.CONV_CYC(4)) i_aats_sequencer (.CORE_CLK(clk), .RST_N(rst_n), .CTL(ctl),
        .TRIGGER_SOURCE_SELECT(sel), .SRC(src), .SLEEP(sleep), .DONE_FLAG_CLR(clr),
        .SAMPLE_IN(sample), .CONVERTER_ON(on), .CONVERSION_GO_BIT(go),
        .CONVERSION_DONE_FLAG(done), .RESULT(result), .HOLD_DISCHARGE());
    aats_src_model i_aats_src_model (.CORE_CLK(clk), .src(src));
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic on_v, input logic go_v);
        @(posedge clk) #1 ctl = '{1'b1, on_v, go_v};
        @(posedge clk) #1 ctl = '0;
    endtask
    // bounded wait for a start, then for its end; clears the done flag after
    task automatic conv(input logic exp_go, input logic [9:0] val);
        int n;
        sample = val;
        for (n = 0; go !== 1'b1 && n < 12; n++) @(posedge clk) #1;
        chk("start", {9'h000, exp_go}, {9'h000, go});
        if (go !== exp_go) give_verdict();
        if (exp_go) begin
            for (n = 0; go === 1'b1 && n < 12; n++) @(posedge clk) #1;
            if (n == 12) begin
                err_total++;
                give_verdict();
            end
            chk("done", 10'h001, {9'h000, done});
            chk("result", val, result);
            @(posedge clk) #1 clr = 1'b1;
            @(posedge clk) #1 clr = 1'b0;
            chk("done clear", 10'h000, {9'h000, done});
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        wr(1'b1, 1'b1);
        chk("same write", 10'h000, {9'h000, go});
        chk("converter on", 10'h001, {9'h000, on});
        repeat (20) @(posedge clk); // acquisition wait
        wr(1'b1, 1'b1);
        conv(1'b1, 10'h3FF);
        $display("software start test done");
        // turning the converter off mid conversion leaves no result
        wr(1'b1, 1'b1);
        wr(1'b0, 1'b0);
        chk("abort go", 10'h000, {9'h000, go});
        chk("converter off", 10'h000, {9'h000, on});
        repeat (8) @(posedge clk);
        #1 chk("abort done", 10'h000, {9'h000, done});
        chk("abort result", 10'h3FF, result);
        wr(1'b1, 1'b0);
        chk("converter back on", 10'h001, {9'h000, on});
        $display("abort test done");
        for (int c = 1; c <= 18; c++) begin
            sel = c[4:0];
            i_aats_src_model.fire(~(18'h00001 << (c - 1)));
            conv(1'b0, 10'h000);
            i_aats_src_model.fire(18'h00001 << (c - 1));
            conv(1'b1, 10'(c * 37));
        end
        $display("source select test done");
        sel = 5'h00;
        i_aats_src_model.fire(18'h3FFFF);
        conv(1'b0, 10'h000);
        sel = 5'h13;
        i_aats_src_model.fire(18'h3FFFF);
        conv(1'b0, 10'h000);
        sel = 5'h01;
        sleep = 1'b1;
        i_aats_src_model.fire(18'h3FFFF);
        conv(1'b0, 10'h000);
        $display("blocked trigger test done");
        give_verdict();
    end
endmodule
bind aats_sequencer aats_sequencer_props i_aats_sequencer_props (.CORE_CLK(CORE_CLK),
    .RST_N(RST_N), .CTL(CTL), .TRIGGER_SOURCE_SELECT(TRIGGER_SOURCE_SELECT), .SRC(SRC),
    .SLEEP(SLEEP), .DONE_FLAG_CLR(DONE_FLAG_CLR), .SAMPLE_IN(SAMPLE_IN),
    .CONVERTER_ON(CONVERTER_ON), .CONVERSION_GO_BIT(CONVERSION_GO_BIT),
    .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG), .RESULT(RESULT),
    .HOLD_DISCHARGE(HOLD_DISCHARGE));
